// File: logic/leig_pkg.sv
// package: register map, field positions and reset values of the link event interrupt group
package leig_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] LEIG_MASK_ADDR  = 8'h7D;
    localparam logic [7:0] LEIG_PEEK_ADDR  = 8'h7E;
    localparam logic [7:0] LEIG_CLEAR_ADDR = 8'h7F;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int LEIG_BIT_WAKE = 5;
    localparam int LEIG_BIT_LINK = 4;
    localparam int LEIG_BIT_JAB  = 3;
    localparam int LEIG_BIT_ANF  = 2;
    localparam int LEIG_BIT_ANC  = 0;

    // implemented bits; 7, 6 and 1 read zero and ignore writes
    localparam logic [7:0] LEIG_IMPL_MASK  = 8'h3D;
    localparam logic [7:0] LEIG_MASK_RESET = 8'h00;
    localparam logic [7:0] LEIG_FLAG_RESET = 8'h00;

endpackage

// File: logic/leig_reset_sync.sv
// two flip-flop synchroniser for the active-low reset release
`timescale 1ns/1ns
module leig_reset_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      srst_n
);
    typedef struct packed {
        logic meta;
        logic sync;
    } leig_sync_state_t;

    leig_sync_state_t sync_reg;
    leig_sync_state_t sync_next;

    // only the second stage is read outside, the first may be metastable
    always_comb begin
        sync_next.meta = 1'b1;
        sync_next.sync = sync_reg.meta;
    end

    // asserts at once, releases after two edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_reg <= '{meta: 1'b0, sync: 1'b0};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign srst_n = sync_reg.sync;
endmodule // leig_reset_sync

// File: logic/leig_top.sv
// link event interrupt group: sticky flags, mask, clear-on-read and mirror status
`timescale 1ns/1ns

// How it works
// - reading 0x7F returns flags, then clears every flag except one whose event edge arrives in the same cycle
// - reading 0x7E returns the same flags and clears nothing
// - wake flag at bit 5 set on network connection, sticky
// - link change flag at bit 4 set on any link status change, sticky
// - jabber flag at bit 3 set on jabber detection, sticky
// - negotiation failed flag at bit 2 set on failure, sticky
// - negotiation done flag at bit 0 set on completion, sticky
// - mirror register shows flags at identical positions, read only
// - bits 7 and 6 read zero in all three registers, writes ignored
// - bit 1 reserved, reads zero; host must write zero there
module leig_top
    import leig_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] ADDR,
    input  wire logic       RD_STB,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WDATA,
    output logic      [7:0] RDATA,
    input  wire logic       EV_CONNECT,
    input  wire logic       EV_LINK_CHANGE,
    input  wire logic       EV_JABBER,
    input  wire logic       EV_NEG_FAILED,
    input  wire logic       EV_NEG_DONE,
    output logic            IRQ
);

    // ****************************************************************
    // reset release and input synchronisers
    // ****************************************************************
    logic rst_n;

    leig_reset_sync u_rst (
        .clk    (CORE_CLK),
        .arst_n (NRST),
        .srst_n (rst_n)
    );

    typedef struct packed {
        logic [4:0] ev_meta;
        logic [4:0] ev_sync;
        logic [4:0] ev_prev;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic       irq;
    } leig_state_t;

    leig_state_t st_reg;
    leig_state_t st_next;

    // event inputs are level pins from the link logic; a rising edge is one event
    logic [7:0] ev_pulse;
    logic       rd_clear;
    logic       rd_peek;

    always_comb begin
        st_next  = st_reg;
        ev_pulse = 8'h00;
        rd_clear = RD_STB && (ADDR == LEIG_CLEAR_ADDR);
        rd_peek  = RD_STB && (ADDR == LEIG_PEEK_ADDR);

        st_next.ev_meta = {EV_CONNECT, EV_LINK_CHANGE, EV_JABBER, EV_NEG_FAILED, EV_NEG_DONE};
        st_next.ev_sync = st_reg.ev_meta;
        st_next.ev_prev = st_reg.ev_sync;

        ev_pulse[LEIG_BIT_WAKE] = st_reg.ev_sync[4] & ~st_reg.ev_prev[4];
        ev_pulse[LEIG_BIT_LINK] = st_reg.ev_sync[3] & ~st_reg.ev_prev[3];
        ev_pulse[LEIG_BIT_JAB]  = st_reg.ev_sync[2] & ~st_reg.ev_prev[2];
        ev_pulse[LEIG_BIT_ANF]  = st_reg.ev_sync[1] & ~st_reg.ev_prev[1];
        ev_pulse[LEIG_BIT_ANC]  = st_reg.ev_sync[0] & ~st_reg.ev_prev[0];

        // ****************************************************************
        // register reads; data registered on the strobe cycle
        // ****************************************************************
        if (RD_STB) begin
            unique case (ADDR)
                LEIG_CLEAR_ADDR: st_next.rdata = st_reg.flags & LEIG_IMPL_MASK;
                LEIG_PEEK_ADDR:  st_next.rdata = st_reg.flags & LEIG_IMPL_MASK;
                LEIG_MASK_ADDR:  st_next.rdata = st_reg.mask & LEIG_IMPL_MASK;
                default:         st_next.rdata = 8'h00;
            endcase
        end

        // clear first, then set: a coincident event survives the clearing read
        if (rd_clear) begin
            st_next.flags = 8'h00;
        end
        st_next.flags = (st_next.flags | ev_pulse) & LEIG_IMPL_MASK;

        // reserved bits dropped so a careless write cannot enable them
        if (WR_STB && (ADDR == LEIG_MASK_ADDR)) begin
            st_next.mask = WDATA & LEIG_IMPL_MASK;
        end

        st_next.irq = |(st_next.flags & st_next.mask);
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{ev_meta: 5'h00, ev_sync: 5'h00, ev_prev: 5'h00,
                        flags: LEIG_FLAG_RESET, mask: LEIG_MASK_RESET,
                        rdata: 8'h00, irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA = st_reg.rdata;
    assign IRQ   = st_reg.irq;

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_clear_read_empties: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_clear && ev_pulse == 8'h00 |=> st_reg.flags == 8'h00)
        else $error("clearing read left a flag set");

    a_clear_read_data: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_clear |=> RDATA == ($past(st_reg.flags) & LEIG_IMPL_MASK))
        else $error("clearing read returned wrong data");

    a_peek_keeps_flags: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_peek |=> (st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags))
        else $error("mirror read cleared a flag");

    a_peek_same_bits: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_peek |=> RDATA == $past(st_reg.flags))
        else $error("mirror read data differs from flags");

    a_jabber_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse[LEIG_BIT_JAB] |=> st_reg.flags[LEIG_BIT_JAB] ##1
        (st_reg.flags[LEIG_BIT_JAB] || $past(rd_clear)))
        else $error("jabber flag not held");

    a_wake_sets: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse[LEIG_BIT_WAKE] |=> st_reg.flags[LEIG_BIT_WAKE])
        else $error("wake flag not set");

    a_event_wins: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_clear && ev_pulse[LEIG_BIT_LINK] |=> st_reg.flags[LEIG_BIT_LINK])
        else $error("event lost to clearing read");

    a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        (RDATA & ~LEIG_IMPL_MASK) == 8'h00 && (st_reg.mask & ~LEIG_IMPL_MASK) == 8'h00)
        else $error("reserved bit reads nonzero");

    a_irq_follows: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        IRQ == |(st_reg.flags & st_reg.mask))
        else $error("interrupt request disagrees with flags and mask");

    a_mask_write: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        WR_STB && ADDR == LEIG_MASK_ADDR |=> st_reg.mask == ($past(WDATA) & LEIG_IMPL_MASK))
        else $error("mask write not stored");

    // ****************************************************************
    // assertions: each flag is set by its own event and then held
    // ****************************************************************
    a_link_sets: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse[LEIG_BIT_LINK] |=> st_reg.flags[LEIG_BIT_LINK])
        else $error("link change flag not set");

    a_neg_failed_sets: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse[LEIG_BIT_ANF] |=> st_reg.flags[LEIG_BIT_ANF])
        else $error("negotiation failed flag not set");

    a_neg_done_sets: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse[LEIG_BIT_ANC] |=> st_reg.flags[LEIG_BIT_ANC])
        else $error("negotiation done flag not set");

    a_wake_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[LEIG_BIT_WAKE] && !rd_clear |=> st_reg.flags[LEIG_BIT_WAKE])
        else $error("wake flag dropped without clearing read");

    a_link_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[LEIG_BIT_LINK] && !rd_clear |=> st_reg.flags[LEIG_BIT_LINK])
        else $error("link change flag dropped without clearing read");

    a_neg_failed_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[LEIG_BIT_ANF] && !rd_clear |=> st_reg.flags[LEIG_BIT_ANF])
        else $error("negotiation failed flag dropped without clearing read");

    a_neg_done_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[LEIG_BIT_ANC] && !rd_clear |=> st_reg.flags[LEIG_BIT_ANC])
        else $error("negotiation done flag dropped without clearing read");

    // a flag that rises on its own would raise a request nobody can explain
    a_flag_needs_event: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        ev_pulse == 8'h00 |=> (st_reg.flags & ~$past(st_reg.flags)) == 8'h00)
        else $error("flag set with no event");

    a_event_all_win: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        rd_clear |=> (st_reg.flags & $past(ev_pulse)) == $past(ev_pulse))
        else $error("coincident event lost to clearing read");

    // ****************************************************************
    // assertions: register access and interrupt request
    // ****************************************************************
    a_bit_one_zero: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[1] == 1'b0 && st_reg.mask[1] == 1'b0 && RDATA[1] == 1'b0)
        else $error("reserved bit one not zero");

    a_mask_other_addr: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        WR_STB && ADDR != LEIG_MASK_ADDR |=> $stable(st_reg.mask))
        else $error("write to another address changed the mask");

    a_write_keeps_flags: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        WR_STB && !rd_clear && ev_pulse == 8'h00 |=> $stable(st_reg.flags))
        else $error("write changed a read only flag");

    a_jabber_irq: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.flags[LEIG_BIT_JAB] && st_reg.mask[LEIG_BIT_JAB] |-> IRQ)
        else $error("enabled jabber flag raised no request");

    a_irq_masked_off: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
        st_reg.mask == 8'h00 |-> !IRQ)
        else $error("request raised with every enable off");

endmodule // leig_top

// File: verification/leig_host_model.sv
// host processor model driving the register strobes of the interrupt group
`timescale 1ns/1ns
module leig_host_model (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic            rd_stb,
    output logic            wr_stb,
    output logic      [7:0] wdata
);
    initial begin
        addr = 8'h00;
        rd_stb = 1'b0;
        wr_stb = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d & 8'hFD;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        // released data must not look like the last value
        wdata  <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask
endmodule // leig_host_model

// File: verification/tb_top.sv
// self-checking bench for the link event interrupt group
`timescale 1ns/1ns
module tb_top;
    import leig_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [7:0] addr, wdata, rdata, d;
    logic       rd_stb, wr_stb, irq, rd_q;
    logic [7:0] exp_q[$];
    int         fail_count = 0;
    int         n_checks = 0;
    int         seed = 19652;
    int         pos[5] = '{LEIG_BIT_WAKE, LEIG_BIT_LINK, LEIG_BIT_JAB, LEIG_BIT_ANF, LEIG_BIT_ANC};
    always #10 clk = ~clk;
    leig_host_model host_inst (.clk(clk), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
        .wdata(wdata));
    leig_top leig_top_inst (.CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .RD_STB(rd_stb),
        .WR_STB(wr_stb), .WDATA(wdata), .RDATA(rdata), .EV_CONNECT(ev[0]),
        .EV_LINK_CHANGE(ev[1]), .EV_JABBER(ev[2]), .EV_NEG_FAILED(ev[3]),
        .EV_NEG_DONE(ev[4]), .IRQ(irq));
    // ****************************************************************
    // compare tasks and monitor
    // ****************************************************************
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input logic e);
        chk8("IRQ", {7'h00, e}, {7'h00, irq});
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_inst.rd(a);
    endtask
    // two event edges must be apart, so the level is dropped again
    task automatic fire(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        repeat (2) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) rd_q <= rd_stb;
    always @(negedge clk) begin
        if (rd_q && exp_q.size() > 0)
            chk8("RDATA", exp_q.pop_front(), rdata);
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rdx(LEIG_MASK_ADDR, LEIG_MASK_RESET);
        rdx(LEIG_PEEK_ADDR, LEIG_FLAG_RESET);
        rdx(LEIG_CLEAR_ADDR, LEIG_FLAG_RESET);
        rdx(8'h10, 8'h00);
        host_inst.wr(LEIG_PEEK_ADDR, 8'hFF);
        host_inst.wr(LEIG_CLEAR_ADDR, 8'hFF);
        rdx(LEIG_PEEK_ADDR, 8'h00);
        host_inst.wr(LEIG_MASK_ADDR, 8'hFF);
        rdx(LEIG_MASK_ADDR, 8'h3D);
        for (int i = 0; i < 5; i++) begin
            fire(i);
            chk1(1'b1);
            rdx(LEIG_PEEK_ADDR, 8'h01 << pos[i]);
            rdx(LEIG_PEEK_ADDR, 8'h01 << pos[i]);
            rdx(LEIG_CLEAR_ADDR, 8'h01 << pos[i]);
            rdx(LEIG_PEEK_ADDR, 8'h00);
            @(negedge clk);
            chk1(1'b0);
        end
        host_inst.wr(LEIG_MASK_ADDR, 8'h08);
        fire(0);
        chk1(1'b0);
        fire(2);
        chk1(1'b1);
        rdx(LEIG_CLEAR_ADDR, 8'h28);
        // link edge reaches the flag in the very cycle the clearing read is taken
        ev[1] <= 1'b1;
        @(posedge clk);
        rdx(LEIG_CLEAR_ADDR, 8'h00);
        rdx(LEIG_CLEAR_ADDR, 8'h10);
        ev[1] <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            host_inst.wr(LEIG_MASK_ADDR, d);
            rdx(LEIG_MASK_ADDR, d & 8'h3D);
        end
        repeat (3) @(posedge clk);
        chk8("notes left", 8'h00, 8'(exp_q.size()));
        finish_test();
    end
endmodule // tb_top
